// >>> src/eeprom_i2c_pkg.sv
// Shared constants and types for the serial EEPROM link and its master.
// Assumes a 25 MHz core clock and a standard two-wire serial bus.
package eeprom_i2c_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CORE_CLK_NS = 40;
  localparam int SCL_PERIOD_NS = 2500;
  // Least SCL period, so the quarter count rounds up.
  localparam int SCL_QTR_CYCLES =
    (SCL_PERIOD_NS + 4 * CORE_CLK_NS - 1) / (4 * CORE_CLK_NS);
  localparam int T_WR_NS = 5000000;
  // Longest write time, so the count rounds down.
  localparam int WR_CYCLES_DFLT = T_WR_NS / CORE_CLK_NS;

  // ****************************************************************
  // Addressing and array layout
  // ****************************************************************
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [1:0] DEV_FIXED = 2'h0;
  localparam int ADDR_W = 15;
  localparam int OFF_W = 6;
  localparam int PAGE_W = ADDR_W - OFF_W;
  localparam int MEM_BYTES = 32768;
  localparam int PAGE_BYTES = 64;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [3:0] BITS = 4'h8;
  localparam logic [OFF_W-1:0] LAST_OFF = 6'h3F;

  // ****************************************************************
  // Master commands
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_START,
    CMD_WRITE,
    CMD_READ,
    CMD_STOP
  } cmd_e;

endpackage

// >>> src/i2c_eeprom_dev.sv
// EEPROM end of the two-wire link: protocol engine, page buffer and array.
// Assumes link_clk_i oversamples SCL and SDA; the write timer runs on
// core_clk_i; the bus master keeps to the bus protocol.
`timescale 1ns/1ps
module i2c_eeprom_dev
  import eeprom_i2c_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DFLT
) (
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic address_select_pin_i,
  input wire logic write_protect_i,
  output logic busy_o,
  i2c_link_if.dev_mp link
);

  localparam int CNT_W = $clog2(WR_CYCLES + 1);

  if (WR_CYCLES < 1) begin : g_chk
    $error("WR_CYCLES must be at least one");
  end

  typedef enum logic [2:0] {
    S_IDLE,
    S_DEV,
    S_AHI,
    S_ALO,
    S_WDAT,
    S_RDAT
  } dev_state_e;

  function automatic logic addr_match(input logic [7:0] b,
                                      input logic sel);
    addr_match = (b[7:4] == DEV_TYPE) && (b[3] == sel) &&
                 (b[2:1] == DEV_FIXED);
  endfunction

  // ****************************************************************
  // Pin sampling and bus conditions
  // ****************************************************************
  logic [3:0] pins_s;
  logic scl_s, sda_s, asel_s, wp_s;
  logic scl_q, sda_q;
  logic start, stop, scl_rise, scl_fall;

  sync2 #(.W(4), .RST(4'hC)) u_pins (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({link.scl, link.sda, address_select_pin_i, write_protect_i}),
    .q_o(pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign asel_s = pins_s[1];
  assign wp_s = pins_s[0];

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign start = scl_s && scl_q && sda_q && !sda_s;
  assign stop = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  dev_state_e state_r;
  logic [3:0] bitcnt_r;
  logic ack_ph_r;
  logic [7:0] shift_r;
  logic sda_oe_r;
  logic [ADDR_W-1:0] addr_r;
  logic [6:0] ahi_r;
  logic [PAGE_W-1:0] page_r;
  logic [OFF_W-1:0] off_r;
  logic wrote_r;
  logic mst_nack_r;
  logic busy_r;
  logic [7:0] rd_data_r;
  logic byte_end, launch, wr_take, alo_take;

  assign byte_end = scl_fall && !ack_ph_r && bitcnt_r == BITS &&
                    !start && !stop && state_r != S_IDLE;
  assign wr_take = byte_end && state_r == S_WDAT && !wp_s;
  assign alo_take = byte_end && state_r == S_ALO;
  // Only a STOP at a clean byte boundary after data launches a write.
  // The STOP's own SCL rise has already counted one bit by then.
  assign launch = stop && wrote_r && state_r == S_WDAT && !ack_ph_r &&
                  bitcnt_r == 4'h1;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      bitcnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      shift_r <= 8'h00;
      sda_oe_r <= 1'b0;
      addr_r <= '0;
      ahi_r <= 7'h00;
      page_r <= '0;
      off_r <= '0;
      wrote_r <= 1'b0;
      mst_nack_r <= 1'b0;
    end else if (start) begin
      state_r <= S_DEV;
      bitcnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wrote_r <= 1'b0;
    end else if (stop) begin
      state_r <= S_IDLE;
      sda_oe_r <= 1'b0;
      wrote_r <= 1'b0;
    end else if (state_r != S_IDLE) begin
      if (scl_rise) begin
        if (!ack_ph_r && bitcnt_r != BITS) begin
          bitcnt_r <= bitcnt_r + 4'h1;
          if (state_r != S_RDAT) begin
            shift_r <= {shift_r[6:0], sda_s};
          end
        end else if (ack_ph_r && state_r == S_RDAT) begin
          mst_nack_r <= sda_s;
        end
      end else if (scl_fall) begin
        if (ack_ph_r) begin
          ack_ph_r <= 1'b0;
          bitcnt_r <= 4'h0;
          if (state_r == S_RDAT && !mst_nack_r) begin
            shift_r <= rd_data_r;
            // Advance as the byte is loaded, so the first one comes
            // from the current address, not the one after it.
            addr_r <= addr_r + 1'b1;
            sda_oe_r <= ~rd_data_r[7];
          end else begin
            sda_oe_r <= 1'b0;
            if (state_r == S_RDAT) begin
              state_r <= S_IDLE;
            end
          end
        end else if (bitcnt_r == BITS) begin
          ack_ph_r <= 1'b1;
          case (state_r)
            S_DEV: begin
              if (addr_match(shift_r, asel_s) && !busy_r) begin
                sda_oe_r <= 1'b1;
                mst_nack_r <= 1'b0;
                state_r <= shift_r[0] ? S_RDAT : S_AHI;
              end else begin
                state_r <= S_IDLE;
              end
            end
            S_AHI: begin
              ahi_r <= shift_r[6:0];
              sda_oe_r <= 1'b1;
              state_r <= S_ALO;
            end
            S_ALO: begin
              addr_r <= {ahi_r, shift_r};
              page_r <= {ahi_r, shift_r[7:6]};
              off_r <= shift_r[5:0];
              sda_oe_r <= 1'b1;
              state_r <= S_WDAT;
            end
            S_WDAT: begin
              if (!wp_s) begin
                sda_oe_r <= 1'b1;
                off_r <= off_r + 1'b1;
                addr_r <= {page_r, off_r + 1'b1};
                wrote_r <= 1'b1;
              end
            end
            S_RDAT: begin
              sda_oe_r <= 1'b0;
            end
            default: begin
              state_r <= S_IDLE;
            end
          endcase
        end else if (state_r == S_RDAT) begin
          shift_r <= {shift_r[6:0], 1'b1};
          sda_oe_r <= ~shift_r[6];
        end
      end
    end
  end

  assign link.sda_d_oe = sda_oe_r;
  assign link.sda_d_o = 1'b0;

  // ****************************************************************
  // Page buffer and array
  // ****************************************************************
  logic [7:0] mem_r [MEM_BYTES] = '{default: ERASED};
  logic [7:0] buf_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_r;
  logic commit_r;
  logic [OFF_W-1:0] cidx_r;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_r <= '0;
    end else if (alo_take) begin
      mask_r <= '0;
    end else if (wr_take) begin
      mask_r[off_r] <= 1'b1;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (wr_take) begin
      buf_r[off_r] <= shift_r;
    end
    if (commit_r && mask_r[cidx_r]) begin
      mem_r[{page_r, cidx_r}] <= buf_r[cidx_r];
    end
    rd_data_r <= mem_r[addr_r];
  end

  // ****************************************************************
  // Internal write cycle
  // ****************************************************************
  logic launch_tgl_r, done_s, done_q;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      launch_tgl_r <= 1'b0;
      commit_r <= 1'b0;
      cidx_r <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= done_s;
      if (launch) begin
        busy_r <= 1'b1;
        launch_tgl_r <= ~launch_tgl_r;
      end else if (done_s != done_q) begin
        commit_r <= 1'b1;
        cidx_r <= '0;
      end else if (commit_r) begin
        cidx_r <= cidx_r + 1'b1;
        if (cidx_r == LAST_OFF) begin
          commit_r <= 1'b0;
          busy_r <= 1'b0;
        end
      end
    end
  end

  logic launch_s, launch_q, done_tgl_r;
  logic [CNT_W-1:0] cnt_r;

  sync2 #(.W(1), .RST(1'b0)) u_launch (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(launch_tgl_r),
    .q_o(launch_s)
  );

  sync2 #(.W(1), .RST(1'b0)) u_done (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(done_tgl_r),
    .q_o(done_s)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      launch_q <= 1'b0;
      busy_o <= 1'b0;
      cnt_r <= '0;
      done_tgl_r <= 1'b0;
    end else begin
      launch_q <= launch_s;
      if (launch_s != launch_q) begin
        busy_o <= 1'b1;
        cnt_r <= CNT_W'(WR_CYCLES - 1);
      end else if (busy_o) begin
        if (cnt_r == '0) begin
          busy_o <= 1'b0;
          done_tgl_r <= ~done_tgl_r;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

endmodule

// >>> src/i2c_eeprom_master.sv
// Bus master end of the two-wire link, driven one command at a time.
// Assumes a single slave clock-free bus; SCL is made here by a divider.
`timescale 1ns/1ps
module i2c_eeprom_master
  import eeprom_i2c_pkg::*;
#(
  parameter int QTR_CYCLES = SCL_QTR_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire cmd_e cmd_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic cmd_rd_ack_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic nack_o,
  i2c_link_if.master_mp link
);

  localparam int QW = $clog2(QTR_CYCLES + 1);

  if (QTR_CYCLES < 4) begin : g_chk
    $error("QTR_CYCLES must be at least four");
  end

  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_STOP
  } mst_state_e;

  mst_state_e state_r;
  logic [QW-1:0] qdiv_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic rd_r, ack_r, scl_r, oe_r;
  logic sda_s, tick, last_q;

  sync2 #(.W(1), .RST(1'b1)) u_sda (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(link.sda),
    .q_o(sda_s)
  );

  assign tick = qdiv_r == '0;
  assign last_q = tick && q_r == 2'h3 &&
                  (state_r != M_BIT || bit_r == BITS);

  // ****************************************************************
  // Quarter-bit divider
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qdiv_r <= '0;
      q_r <= 2'h0;
    end else if (state_r == M_IDLE) begin
      qdiv_r <= QW'(QTR_CYCLES - 1);
      q_r <= 2'h0;
    end else if (tick) begin
      qdiv_r <= QW'(QTR_CYCLES - 1);
      q_r <= q_r + 2'h1;
    end else begin
      qdiv_r <= qdiv_r - 1'b1;
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= M_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      cmd_ready_o <= 1'b1;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      nack_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        M_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            bit_r <= 4'h0;
            sh_r <= cmd_wdata_i;
            rd_r <= cmd_i == CMD_READ;
            ack_r <= cmd_rd_ack_i;
            case (cmd_i)
              CMD_START: state_r <= M_START;
              CMD_STOP: state_r <= M_STOP;
              default: state_r <= M_BIT;
            endcase
          end
        end
        M_START: begin
          if (tick) begin
            case (q_r)
              2'h0: oe_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b1;
              default: scl_r <= 1'b0;
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            case (q_r)
              2'h0: oe_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b0;
              default: scl_r <= 1'b1;
            endcase
          end
        end
        M_BIT: begin
          if (tick) begin
            case (q_r)
              2'h0: begin
                if (bit_r != BITS) begin
                  oe_r <= !rd_r && !sh_r[7];
                end else begin
                  oe_r <= rd_r && ack_r;
                end
              end
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (bit_r != BITS) begin
                  sh_r <= {sh_r[6:0], sda_s};
                end else if (!rd_r) begin
                  nack_o <= sda_s;
                end
              end
              default: begin
                scl_r <= 1'b0;
                bit_r <= bit_r + 4'h1;
              end
            endcase
          end
        end
        default: state_r <= M_IDLE;
      endcase
      if (last_q) begin
        state_r <= M_IDLE;
        cmd_ready_o <= 1'b1;
        done_o <= 1'b1;
        if (state_r == M_BIT && rd_r) begin
          rdata_o <= sh_r;
        end
      end
    end
  end

  assign link.scl = scl_r;
  assign link.sda_m_oe = oe_r;
  assign link.sda_m_o = 1'b0;

endmodule

// >>> src/i2c_link_if.sv
// Two-wire link between the EEPROM end and the bus master end.
// SDA is open drain with a pull-up; the wire level comes from the enables.
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;

  // Pull-up: the line is low only where a driver is enabled with a zero.
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));

  modport master_mp (
    output scl,
    output sda_m_o,
    output sda_m_oe,
    input sda
  );
  modport dev_mp (
    input scl,
    input sda,
    output sda_d_o,
    output sda_d_oe
  );
endinterface

// >>> src/sync2.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes the reader only looks at q_o, never at the first stage.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST;
      q_o <= RST;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// >>> test/eeprom_link_sva.sv
// Checker for the two-wire link between the EEPROM end and its master.
// Assumes it sits beside the link interface and sees the wire levels.
`timescale 1ns/1ps
module eeprom_link_sva
  import eeprom_i2c_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DFLT
) (
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic busy_o,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_o,
  input wire logic sda_d_oe
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic scl_r, sda_r, c_scl_r, c_sda_r;
  logic [3:0] rises_r, bitpos_r;
  logic [7:0] addr_r;
  logic [15:0] stop_age_r;
  logic [31:0] busy_cnt_r;
  logic start_w, rise_w, stop_c;
  assign start_w = scl_r & scl & sda_r & ~sda;
  assign rise_w = scl & ~scl_r;
  assign stop_c = c_scl_r & scl & ~c_sda_r & sda;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end

  // Rises since the last START and position within the nine-bit frame.
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rises_r <= 4'h0;
      bitpos_r <= 4'h0;
    end else if (start_w) begin
      rises_r <= 4'h0;
      bitpos_r <= 4'h0;
    end else if (rise_w) begin
      rises_r <= (rises_r == 4'hF) ? rises_r : rises_r + 4'h1;
      bitpos_r <= (bitpos_r == 4'h8) ? 4'h0 : bitpos_r + 4'h1;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= 8'h00;
    end else if (rise_w && rises_r < 4'h8) begin
      addr_r <= {addr_r[6:0], sda};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_scl_r <= 1'b1;
      c_sda_r <= 1'b1;
      stop_age_r <= 16'hFFFF;
      busy_cnt_r <= 32'h00000000;
    end else begin
      c_scl_r <= scl;
      c_sda_r <= sda;
      stop_age_r <= stop_c ? 16'h0000 :
        ((stop_age_r == 16'hFFFF) ? stop_age_r : stop_age_r + 16'h0001);
      busy_cnt_r <= busy_o ? busy_cnt_r + 32'h00000001 : 32'h00000000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_drive_low_only: assert property (@(posedge link_clk_i)
    disable iff (!rst_n_i) sda_d_oe |-> !sda_d_o)
    else $error("device drives SDA high");
  a_change_scl_low: assert property (@(posedge link_clk_i)
    disable iff (!rst_n_i) $changed(sda_d_oe) |-> !scl)
    else $error("device changed SDA while SCL high");
  a_addr_quiet: assert property (@(posedge link_clk_i)
    disable iff (!rst_n_i) (rises_r < 4'h8) |-> !sda_d_oe)
    else $error("device drove SDA during address byte");
  a_ack_holds: assert property (@(posedge link_clk_i)
    disable iff (!rst_n_i)
    (rise_w && bitpos_r == 4'h8 && sda_d_oe) |=> sda_d_oe [*3])
    else $error("acknowledge dropped in ninth clock");
  a_addr_match: assert property (@(posedge link_clk_i)
    disable iff (!rst_n_i) (rises_r == 4'h8 &&
    (addr_r[7:4] != DEV_TYPE || addr_r[2:1] != DEV_FIXED)) |-> !sda_d_oe)
    else $error("device answered a foreign address");
  a_busy_no_ack: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) busy_o |-> !sda_d_oe)
    else $error("device acknowledged while busy");
  a_busy_len: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) $fell(busy_o) |->
    (busy_cnt_r >= 32'(WR_CYCLES - 1) && busy_cnt_r <= 32'(WR_CYCLES + 1)))
    else $error("write interval has wrong length");
  a_busy_after_stop: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) $rose(busy_o) |-> stop_age_r < 16'h0008)
    else $error("write cycle began without a STOP");

  c_ack: cover property (@(posedge link_clk_i) disable iff (!rst_n_i)
    rise_w && bitpos_r == 4'h8 && sda_d_oe);
  c_read_data: cover property (@(posedge link_clk_i)
    disable iff (!rst_n_i) sda_d_oe && bitpos_r != 4'h8);
  c_busy: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(busy_o));
endmodule

// >>> test/tb_i2c_serial_eeprom_slave.sv
// Self-checking bench: master end drives the EEPROM end over the link.
// Assumes a shortened write interval and a fast SCL divider.
`timescale 1ns/1ps
module tb_i2c_serial_eeprom_slave;
  import eeprom_i2c_pkg::*;
  localparam int WR = 600;
  localparam int Q = 6;
  logic core_clk_i, link_clk_i, rst_n_i, address_select_pin_i;
  logic write_protect_i, busy_o, cmd_valid_i, cmd_rd_ack_i;
  logic cmd_ready_o, done_o, nack_o;
  cmd_e cmd_i;
  logic [7:0] cmd_wdata_i, rdata_o;
  int failures, samples_checked;
  i2c_link_if i2c_link_if_inst ();
  i2c_eeprom_dev #(.WR_CYCLES(WR)) i2c_eeprom_dev_inst (
    .core_clk_i(core_clk_i), .link_clk_i(link_clk_i), .rst_n_i(rst_n_i),
    .address_select_pin_i(address_select_pin_i),
    .write_protect_i(write_protect_i), .busy_o(busy_o),
    .link(i2c_link_if_inst));
  i2c_eeprom_master #(.QTR_CYCLES(Q)) i2c_eeprom_master_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_wdata_i(cmd_wdata_i), .cmd_rd_ack_i(cmd_rd_ack_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .nack_o(nack_o), .link(i2c_link_if_inst));
  eeprom_link_sva #(.WR_CYCLES(WR)) eeprom_link_sva_inst (
    .core_clk_i(core_clk_i), .link_clk_i(link_clk_i), .rst_n_i(rst_n_i),
    .busy_o(busy_o), .scl(i2c_link_if_inst.scl),
    .sda(i2c_link_if_inst.sda), .sda_d_o(i2c_link_if_inst.sda_d_o),
    .sda_d_oe(i2c_link_if_inst.sda_d_oe));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3;
    forever #6 link_clk_i = ~link_clk_i;
  end

  // ****************************************************************
  // Compare and access tasks
  // ****************************************************************
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_cmd(input cmd_e c, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    @(posedge core_clk_i);
    #1;
    while (cmd_ready_o !== 1'b1 && n < 9000) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    cmd_valid_i = 1'b1;
    cmd_i = c;
    cmd_wdata_i = d;
    cmd_rd_ack_i = a;
    @(posedge core_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 9000) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n >= 9000) begin
      failures++;
      $display("MISMATCH t=%0t command never completed", $time);
    end
  endtask
  function automatic logic [7:0] dev_addr(input logic rw);
    return {DEV_TYPE, address_select_pin_i, DEV_FIXED, rw};
  endfunction
  task automatic st();
    do_cmd(CMD_START, 8'h00, 1'b0);
  endtask
  task automatic sp();
    do_cmd(CMD_STOP, 8'h00, 1'b0);
  endtask
  task automatic wr(input logic [7:0] d, input logic exp_nack);
    do_cmd(CMD_WRITE, d, 1'b0);
    check_bit(nack_o, exp_nack);
  endtask
  task automatic rd(input logic ack, input logic [7:0] exp);
    do_cmd(CMD_READ, 8'h00, ack);
    check_byte(rdata_o, exp);
  endtask
  task automatic set_addr(input logic [14:0] a);
    st();
    wr(dev_addr(1'b0), 1'b0);
    wr({1'b0, a[14:8]}, 1'b0);
    wr(a[7:0], 1'b0);
  endtask
  task automatic rand_read(input logic [14:0] a, input logic [7:0] exp);
    set_addr(a);
    st();
    wr(dev_addr(1'b1), 1'b0);
    rd(1'b0, exp);
    sp();
  endtask
  task automatic wait_ready();
    int k;
    logic got;
    k = 0;
    got = 1'b1;
    while (got !== 1'b0 && k < 50) begin
      st();
      do_cmd(CMD_WRITE, dev_addr(1'b0), 1'b0);
      got = nack_o;
      sp();
      k++;
    end
    check_bit(got, 1'b0);
  endtask

  task automatic final_report();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk_i);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [7:0] bad [4] = '{8'h10, 8'h08, 8'h04, 8'h02};
    failures = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    address_select_pin_i = 1'b0;
    write_protect_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = CMD_START;
    cmd_wdata_i = 8'h00;
    cmd_rd_ack_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    rand_read(15'h0123, ERASED);
    foreach (bad[i]) begin
      st();
      wr(dev_addr(1'b0) ^ bad[i], 1'b1);
      sp();
    end
    set_addr(15'h0005);
    wr(8'h5A, 1'b0);
    sp();
    st();
    wr(dev_addr(1'b0), 1'b1);
    sp();
    st();
    wr(dev_addr(1'b1), 1'b1);
    sp();
    wait_ready();
    rand_read(15'h0005, 8'h5A);
    rand_read(15'h0004, ERASED);
    st();
    wr(dev_addr(1'b1), 1'b0);
    rd(1'b0, 8'h5A);
    sp();
    set_addr(15'h007E);
    wr(8'h11, 1'b0);
    wr(8'h22, 1'b0);
    wr(8'h33, 1'b0);
    sp();
    wait_ready();
    set_addr(15'h007E);
    st();
    wr(dev_addr(1'b1), 1'b0);
    rd(1'b1, 8'h11);
    rd(1'b1, 8'h22);
    rd(1'b0, ERASED);
    sp();
    rand_read(15'h0040, 8'h33);
    set_addr(15'h0000);
    wr(8'hC3, 1'b0);
    sp();
    wait_ready();
    set_addr(15'h7FFF);
    st();
    wr(dev_addr(1'b1), 1'b0);
    rd(1'b1, ERASED);
    rd(1'b0, 8'hC3);
    sp();
    write_protect_i = 1'b1;
    set_addr(15'h0005);
    wr(8'h00, 1'b1);
    sp();
    st();
    wr(dev_addr(1'b0), 1'b0);
    sp();
    @(posedge core_clk_i);
    #1;
    write_protect_i = 1'b0;
    rand_read(15'h0005, 8'h5A);
    set_addr(15'h0010);
    sp();
    st();
    wr(dev_addr(1'b0), 1'b0);
    sp();
    rand_read(15'h0010, ERASED);
    @(posedge core_clk_i);
    #1;
    address_select_pin_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    st();
    wr(dev_addr(1'b0), 1'b0);
    sp();
    st();
    wr(8'hA0, 1'b1);
    sp();
    final_report();
  end
endmodule
